// >>> verilog/cmpreg_top.sv
// comparator control register block with AXI4-Lite slave and change interrupt
// assumes the raw comparator decision arrives synchronous to clock_in
//
// Summary of operation
// - one instance: a control and an offset trim register, bit 7 unused.
// - control holds enable b6, polarity b5, result b4, response time b3..2.
// - polarity bit is read-write, resets to 0, 1 means inverted.
// - polarity 0 passes raw decision; polarity 1 inverts it.
// - result bit is read-only, reads 0 while disabled, else 1 when plus input exceeds minus, unless inverted.
// - response time code 00 slowest, 01 and 10 middle, 11 fastest.
// - trim holds calibration mode b6, reference select b5, five-bit value b4..0.
// - a change of conditioned result while enabled sets the change flag; enabled flag interrupts.
`timescale 1ns/100ps
`include "cmpreg_map.svh"

module cmpreg_top
    import cmpreg_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic        clk_en_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        comp_raw_in,
    output logic             comparator_enable_out,
    output cmpreg_resp_time_e response_time_sel_out,
    output logic             calibration_mode_select_out,
    output logic             calibration_reference_select_out,
    output logic [4:0]       offset_trim_value_out,
    output logic             comparator_result_out,
    output logic             irq_out
);

    cmpreg_cond_if cond_if ();

    // register state
    cmpreg_byte_t      comparator_control_reg;
    cmpreg_byte_t      comparator_offset_trim_reg;
    cmpreg_byte_t      irq_status_reg;
    cmpreg_byte_t      irq_status_next;
    cmpreg_byte_t      irq_mask_reg;
    logic              irq_reg;

    // write channel state
    logic              awready_reg;
    logic              wready_reg;
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [7:0]        waddr_reg;
    logic [7:0]        wdata_reg;
    logic              wstrb0_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              do_write;
    logic              write_mapped;

    // read channel state
    logic              arready_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic [7:0]        rsel_reg;
    logic              ar_take;
    cmpreg_byte_t      rd_byte;
    logic              rd_mapped;
    logic              stat_read;

    // conditioner hookup
    assign cond_if.enable   = comparator_control_reg[`CMPREG_CTRL_EN_BIT];
    assign cond_if.polarity = comparator_control_reg[`CMPREG_CTRL_POL_BIT];
    assign cond_if.raw      = comp_raw_in;

    cmpreg_cond u_cond (
        .clock_in  (clock_in),
        .srst_in   (srst_in),
        .clk_en_in (clk_en_in),
        .cond_if   (cond_if)
    );

    // ---------------- write path ----------------
    assign do_write     = aw_held_reg && w_held_reg && !bvalid_reg;
    assign write_mapped = (waddr_reg == `CMPREG_CTRL_OFS) || (waddr_reg == `CMPREG_TRIM_OFS)
                       || (waddr_reg == `CMPREG_STAT_OFS) || (waddr_reg == `CMPREG_MASK_OFS);

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            awready_reg <= 1'b1;
            aw_held_reg <= 1'b0;
            waddr_reg   <= 8'h00;
        end else if (clk_en_in) begin
            if (s_axi_awvalid_in && awready_reg) begin
                awready_reg <= 1'b0;
                aw_held_reg <= 1'b1;
                waddr_reg   <= s_axi_awaddr_in;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end else if (bvalid_reg && s_axi_bready_in) begin
                awready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wready_reg <= 1'b1;
            w_held_reg <= 1'b0;
            wdata_reg  <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (s_axi_wvalid_in && wready_reg) begin
                wready_reg <= 1'b0;
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_in[7:0];
                wstrb0_reg <= s_axi_wstrb_in[0];
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end else if (bvalid_reg && s_axi_bready_in) begin
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `CMPREG_RESP_OKAY;
        end else if (clk_en_in) begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= write_mapped ? `CMPREG_RESP_OKAY : `CMPREG_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // control: only enable, polarity and response time are writable
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            comparator_control_reg <= `CMPREG_CTRL_RST;
        end else if (clk_en_in && do_write && wstrb0_reg
                     && waddr_reg == `CMPREG_CTRL_OFS) begin
            comparator_control_reg <= wdata_reg & `CMPREG_CTRL_WMASK;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            comparator_offset_trim_reg <= `CMPREG_TRIM_RST;
        end else if (clk_en_in && do_write && wstrb0_reg
                     && waddr_reg == `CMPREG_TRIM_OFS) begin
            comparator_offset_trim_reg <= wdata_reg & `CMPREG_TRIM_WMASK;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_mask_reg <= `CMPREG_MASK_RST;
        end else if (clk_en_in && do_write && wstrb0_reg
                     && waddr_reg == `CMPREG_MASK_OFS) begin
            irq_mask_reg <= wdata_reg & `CMPREG_MASK_WMASK;
        end
    end

    // ---------------- interrupt ----------------
    // read of status clears it; a change in the same cycle wins
    assign stat_read = ar_take && (s_axi_araddr_in == `CMPREG_STAT_OFS);

    always_comb begin
        irq_status_next = stat_read ? 8'h00 : irq_status_reg;
        if (cond_if.changed) begin
            irq_status_next[`CMPREG_STAT_CHG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_status_reg <= `CMPREG_STAT_RST;
            irq_reg        <= 1'b0;
        end else if (clk_en_in) begin
            irq_status_reg <= irq_status_next;
            irq_reg        <= |(irq_status_next & irq_mask_reg);
        end
    end

    // ---------------- read path ----------------
    assign ar_take = s_axi_arvalid_in && arready_reg;

    always_comb begin
        rd_byte   = 8'h00;
        rd_mapped = 1'b1;
        unique case (s_axi_araddr_in)
            `CMPREG_CTRL_OFS: begin
                rd_byte = comparator_control_reg;
                rd_byte[`CMPREG_CTRL_RES_BIT] = cond_if.result;
            end
            `CMPREG_TRIM_OFS: rd_byte = comparator_offset_trim_reg;
            `CMPREG_STAT_OFS: rd_byte = irq_status_reg;
            `CMPREG_MASK_OFS: rd_byte = irq_mask_reg;
            default:          rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `CMPREG_RESP_OKAY;
            rsel_reg    <= 8'h00;
        end else if (clk_en_in) begin
            if (ar_take) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= {24'h00_0000, rd_byte};
                rresp_reg   <= rd_mapped ? `CMPREG_RESP_OKAY : `CMPREG_RESP_SLVERR;
                rsel_reg    <= s_axi_araddr_in;
            end else if (rvalid_reg && s_axi_rready_in) begin
                arready_reg <= 1'b1;
                rvalid_reg  <= 1'b0;
            end
        end
    end

    // ---------------- outputs ----------------
    assign s_axi_awready_out  = awready_reg;
    assign s_axi_wready_out   = wready_reg;
    assign s_axi_bvalid_out   = bvalid_reg;
    assign s_axi_bresp_out    = bresp_reg;
    assign s_axi_arready_out  = arready_reg;
    assign s_axi_rvalid_out   = rvalid_reg;
    assign s_axi_rdata_out    = rdata_reg;
    assign s_axi_rresp_out    = rresp_reg;

    assign comparator_enable_out            = comparator_control_reg[`CMPREG_CTRL_EN_BIT];
    assign response_time_sel_out            = cmpreg_resp_time_e'(
        comparator_control_reg[`CMPREG_CTRL_RT_HI:`CMPREG_CTRL_RT_LO]);
    assign calibration_mode_select_out      = comparator_offset_trim_reg[`CMPREG_TRIM_CAL_BIT];
    assign calibration_reference_select_out = comparator_offset_trim_reg[`CMPREG_TRIM_REF_BIT];
    assign offset_trim_value_out            =
        comparator_offset_trim_reg[`CMPREG_TRIM_VAL_HI:`CMPREG_TRIM_VAL_LO];
    assign comparator_result_out            = cond_if.result;
    assign irq_out                          = irq_reg;

    // ---------------- checks ----------------
    chk_ctrl_unused_zero: assert property (@(posedge clock_in) disable iff (srst_in)
        $rose(rvalid_reg) && rsel_reg == `CMPREG_CTRL_OFS
        |-> rdata_reg[7] == 1'b0 && rdata_reg[1:0] == 2'h0)
        else $error("unused control bits read nonzero");

    chk_trim_top_zero: assert property (@(posedge clock_in) disable iff (srst_in)
        $rose(rvalid_reg) && rsel_reg == `CMPREG_TRIM_OFS |-> rdata_reg[7] == 1'b0)
        else $error("trim bit 7 read nonzero");

    chk_ctrl_write_fields: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && do_write && wstrb0_reg && waddr_reg == `CMPREG_CTRL_OFS
        |=> comparator_enable_out == $past(wdata_reg[6])
            && comparator_control_reg[`CMPREG_CTRL_POL_BIT] == $past(wdata_reg[5])
            && comparator_control_reg[`CMPREG_CTRL_RES_BIT] == 1'b0)
        else $error("control write stored wrong fields");

    chk_pol_reset_zero: assert property (@(posedge clock_in)
        srst_in |=> comparator_control_reg[`CMPREG_CTRL_POL_BIT] == 1'b0
                    && comparator_offset_trim_reg == `CMPREG_TRIM_RST)
        else $error("reset values wrong");

    chk_result_readback: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && ar_take && s_axi_araddr_in == `CMPREG_CTRL_OFS
        |=> rdata_reg[`CMPREG_CTRL_RES_BIT] == $past(cond_if.result))
        else $error("result bit readback mismatch");

    chk_resp_time_out: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && do_write && wstrb0_reg && waddr_reg == `CMPREG_CTRL_OFS
        |=> response_time_sel_out == cmpreg_resp_time_e'($past(wdata_reg[3:2])))
        else $error("response time select not applied");

    chk_trim_fields: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && do_write && wstrb0_reg && waddr_reg == `CMPREG_TRIM_OFS
        |=> offset_trim_value_out == $past(wdata_reg[4:0])
            && calibration_mode_select_out == $past(wdata_reg[6])
            && calibration_reference_select_out == $past(wdata_reg[5]))
        else $error("trim fields not applied");

    chk_change_sets_flag: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && cond_if.changed |=> irq_status_reg[`CMPREG_STAT_CHG_BIT]
                                        && (irq_out == $past(irq_mask_reg[`CMPREG_STAT_CHG_BIT])))
        else $error("change did not raise flag and interrupt");

endmodule // cmpreg_top

// >>> common/cmpreg_map.svh
// comparator control register block: offsets, field positions, reset values
// assumes byte addresses on an 8-bit AXI4-Lite address, one word per register
`ifndef CMPREG_MAP_SVH
`define CMPREG_MAP_SVH

`define CMPREG_CTRL_OFS      8'h00
`define CMPREG_TRIM_OFS      8'h04
`define CMPREG_STAT_OFS      8'h08
`define CMPREG_MASK_OFS      8'h0C

`define CMPREG_CTRL_EN_BIT   6
`define CMPREG_CTRL_POL_BIT  5
`define CMPREG_CTRL_RES_BIT  4
`define CMPREG_CTRL_RT_HI    3
`define CMPREG_CTRL_RT_LO    2

`define CMPREG_TRIM_CAL_BIT  6
`define CMPREG_TRIM_REF_BIT  5
`define CMPREG_TRIM_VAL_HI   4
`define CMPREG_TRIM_VAL_LO   0

`define CMPREG_STAT_CHG_BIT  0

`define CMPREG_CTRL_RST      8'h00
`define CMPREG_TRIM_RST      8'h10
`define CMPREG_STAT_RST      8'h00
`define CMPREG_MASK_RST      8'h00

`define CMPREG_CTRL_WMASK    8'h6C
`define CMPREG_TRIM_WMASK    8'h7F
`define CMPREG_MASK_WMASK    8'h01

`define CMPREG_RESP_OKAY     2'h0
`define CMPREG_RESP_SLVERR   2'h2

`endif

// >>> common/cmpreg_pkg.sv
// comparator control register block: shared types
// assumes cmpreg_map.svh supplies the numeric constants
package cmpreg_pkg;

    // response time codes, slowest first
    typedef enum logic [1:0] {
        CMPREG_RT_SLOWEST,
        CMPREG_RT_MID1,
        CMPREG_RT_MID2,
        CMPREG_RT_FASTEST
    } cmpreg_resp_time_e;

    typedef logic [7:0] cmpreg_byte_t;

endpackage

// >>> common/cmpreg_cond_if.sv
// comparator control register block: carrier between registers and conditioner
// assumes one clock shared by both ends
`timescale 1ns/100ps

interface cmpreg_cond_if;
    logic enable;
    logic polarity;
    logic raw;
    logic result;
    logic changed;

    modport regs (output enable, output polarity, output raw,
                  input result, input changed);
    modport cond (input enable, input polarity, input raw,
                  output result, output changed);
endinterface

// >>> verilog/cmpreg_cond.sv
// comparator result conditioning: polarity, disabled reads 0, change detect
// assumes the raw decision is synchronous to clock_in
`timescale 1ns/100ps

module cmpreg_cond
    import cmpreg_pkg::*;
(
    input  wire logic   clock_in,
    input  wire logic   srst_in,
    input  wire logic   clk_en_in,
    cmpreg_cond_if.cond cond_if
);

    logic result_reg;
    logic result_next;
    logic changed_reg;

    // disabled comparator reads as 0
    assign result_next = cond_if.enable ? (cond_if.raw ^ cond_if.polarity) : 1'b0;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            result_reg  <= 1'b0;
            changed_reg <= 1'b0;
        end else if (clk_en_in) begin
            result_reg  <= result_next;
            changed_reg <= cond_if.enable && (result_next != result_reg);
        end
    end

    assign cond_if.result  = result_reg;
    assign cond_if.changed = changed_reg;

    chk_result_noninv: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && cond_if.enable && !cond_if.polarity |=> result_reg == $past(cond_if.raw))
        else $error("result does not follow raw decision");

    chk_result_inverted: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && cond_if.enable && cond_if.polarity |=> result_reg != $past(cond_if.raw))
        else $error("result not inverted with polarity set");

    chk_disabled_quiet: assert property (@(posedge clock_in) disable iff (srst_in)
        clk_en_in && !cond_if.enable |=> !result_reg && !changed_reg)
        else $error("disabled comparator moved result or flagged change");

endmodule // cmpreg_cond

// >>> test/cmpreg_top_tb.sv
// self-checking bench for the comparator control register block
// assumes the design files and cmpreg_map.svh, cmpreg_pkg are compiled first
`timescale 1ns/100ps
`include "cmpreg_map.svh"

module cmpreg_top_tb
    import cmpreg_pkg::*;
;
    logic              clock_in, srst_in, clk_en_in, comp_raw_in;
    logic [7:0]        awaddr, araddr;
    logic              awvalid, wvalid, bready, arvalid, rready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              en_out, cal_out, ref_out, res_out, irq_out;
    cmpreg_resp_time_e rt_out;
    logic [4:0]        trim_out;
    int                miscompares, compares;
    logic [31:0]       seed;
    logic [31:0]       rd;
    logic [1:0]        rsp;
    logic [7:0]        v;

    cmpreg_top u_cmpreg_top (
        .clock_in(clock_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .comp_raw_in(comp_raw_in),
        .comparator_enable_out(en_out), .response_time_sel_out(rt_out),
        .calibration_mode_select_out(cal_out), .calibration_reference_select_out(ref_out),
        .offset_trim_value_out(trim_out), .comparator_result_out(res_out), .irq_out(irq_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // control readback: writable bits plus live result in bit 4
    function automatic logic [31:0] exp_ctrl(input logic [7:0] w, input logic raw);
        logic r;
        r = w[6] ? (raw ^ w[5]) : 1'b0;
        return {24'h0, (w & `CMPREG_CTRL_WMASK) | {3'h0, r, 4'h0}};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_up();
        miscompares++;
        $display("timeout at %0t waiting for a bus answer", $time);
        tally_and_finish();
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        logic aw_done, w_done;
        int   n;
        @(posedge clock_in);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {rnd() & 32'hFFFF_FF00} | {24'h0, d};
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        n = 0;
        while (!(aw_done && w_done)) begin
            @(posedge clock_in);
            if (awvalid && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (++n > 50) give_up();
        end
        n = 0;
        do begin
            @(posedge clock_in);
            if (++n > 50) give_up();
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge clock_in);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            if (++n > 50) give_up();
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock_in);
            if (++n > 50) give_up();
        end while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        seed = 32'd68219;
        miscompares = 0;
        compares = 0;
        srst_in = 1'b1;
        clk_en_in = 1'b1;
        comp_raw_in = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        cycles(2);
        srst_in <= 1'b0;

        // reset values, unmapped place, refused store
        axi_read(`CMPREG_CTRL_OFS, rd, rsp); check(rd, 32'h0);
        axi_read(`CMPREG_TRIM_OFS, rd, rsp); check(rd, 32'h10);
        check({31'h0, en_out}, 32'h0); check({30'h0, rt_out}, 32'h0);
        axi_read(8'h10, rd, rsp); check({rd[29:0], rsp}, {30'h0, 2'h2});
        axi_write(8'h10, 8'hFF, 4'h1, rsp); check({30'h0, rsp}, 32'h2);
        axi_write(`CMPREG_TRIM_OFS, 8'hFF, 4'h0, rsp); check({30'h0, rsp}, 32'h0);
        axi_read(`CMPREG_TRIM_OFS, rd, rsp); check(rd, 32'h10);
        $display("test reset_and_map done");

        // every response code, random other fields, trim fields
        for (int i = 0; i < 4; i++) begin
            v = 8'(rnd());
            v[3:2] = 2'(i);
            comp_raw_in <= v[0];
            axi_write(`CMPREG_CTRL_OFS, v, 4'h1, rsp);
            cycles(3);
            axi_read(`CMPREG_CTRL_OFS, rd, rsp); check(rd, exp_ctrl(v, v[0]));
            check({30'h0, rt_out}, i); check({31'h0, en_out}, {31'h0, v[6]});
            v = 8'(rnd());
            axi_write(`CMPREG_TRIM_OFS, v, 4'h1, rsp);
            axi_read(`CMPREG_TRIM_OFS, rd, rsp); check(rd, {24'h0, v & 8'h7F});
            check({25'h0, cal_out, ref_out, trim_out}, {25'h0, v[6:0]});
        end
        $display("test fields done");

        // polarity and raw decision, then disabled reads 0
        for (int i = 0; i < 4; i++) begin
            v = {1'b0, 1'b1, i[1], 5'h0};
            comp_raw_in <= i[0];
            axi_write(`CMPREG_CTRL_OFS, v, 4'h1, rsp);
            cycles(3);
            check({31'h0, res_out}, {31'h0, i[0] ^ i[1]});
            axi_read(`CMPREG_CTRL_OFS, rd, rsp); check(rd, exp_ctrl(v, i[0]));
        end
        // frozen clock enable holds the result
        clk_en_in <= 1'b0;
        comp_raw_in <= 1'b0;
        cycles(3);
        check({31'h0, res_out}, 32'h0);
        clk_en_in <= 1'b1;
        cycles(3);
        check({31'h0, res_out}, 32'h1);
        axi_write(`CMPREG_CTRL_OFS, 8'h20, 4'h1, rsp);
        axi_read(`CMPREG_STAT_OFS, rd, rsp);
        for (int i = 0; i < 6; i++) begin
            comp_raw_in <= ~comp_raw_in;
            cycles(2);
            check({31'h0, res_out}, 32'h0);
        end
        axi_read(`CMPREG_STAT_OFS, rd, rsp); check(rd, 32'h0);
        $display("test polarity done");

        // change flag, mask, read clear
        axi_write(`CMPREG_MASK_OFS, 8'h01, 4'h1, rsp);
        comp_raw_in <= 1'b0;
        axi_write(`CMPREG_CTRL_OFS, 8'h40, 4'h1, rsp);
        cycles(4);
        axi_read(`CMPREG_STAT_OFS, rd, rsp);
        cycles(3);
        check({31'h0, irq_out}, 32'h0);
        comp_raw_in <= 1'b1;
        cycles(5);
        check({31'h0, irq_out}, 32'h1);
        axi_write(`CMPREG_STAT_OFS, 8'h00, 4'h1, rsp);
        axi_read(`CMPREG_STAT_OFS, rd, rsp); check(rd, 32'h1);
        cycles(3);
        check({31'h0, irq_out}, 32'h0);
        axi_write(`CMPREG_MASK_OFS, 8'h00, 4'h1, rsp);
        comp_raw_in <= 1'b0;
        cycles(5);
        check({31'h0, irq_out}, 32'h0);
        axi_read(`CMPREG_STAT_OFS, rd, rsp); check(rd, 32'h1);
        comp_raw_in <= 1'b1;
        cycles(4);
        axi_read(`CMPREG_STAT_OFS, rd, rsp);
        axi_write(`CMPREG_CTRL_OFS, 8'h00, 4'h1, rsp);
        cycles(4);
        axi_read(`CMPREG_STAT_OFS, rd, rsp); check(rd, 32'h0);
        $display("test interrupt done");

        // mid-run reset restores registers
        axi_write(`CMPREG_MASK_OFS, 8'hFF, 4'h1, rsp);
        axi_read(`CMPREG_MASK_OFS, rd, rsp); check(rd, 32'h1);
        srst_in <= 1'b1;
        cycles(2);
        srst_in <= 1'b0;
        axi_read(`CMPREG_TRIM_OFS, rd, rsp); check(rd, 32'h10);
        axi_read(`CMPREG_MASK_OFS, rd, rsp); check({rd[29:0], rsp}, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        $display("test midrun_reset done");
        tally_and_finish();
    end
endmodule // cmpreg_top_tb
